// ---- rtl/tafm_pkg.sv ----
// Package with register map, field layout and decision carriers of the trunk/mirror forwarder
package tafm_pkg;
    localparam int NPORT = 10;
    localparam int NTRUNK = 8;
    localparam int NHASH = 8;
    localparam int PW = 4;
    localparam int AW = 12;

    localparam logic [AW-1:0] OFF_CTRL = 12'h000;
    localparam logic [AW-1:0] OFF_STAT = 12'h004;
    localparam logic [AW-1:0] OFF_FSRC_LO = 12'h010;
    localparam logic [AW-1:0] OFF_FSRC_HI = 12'h014;
    localparam logic [AW-1:0] OFF_FDST_LO = 12'h018;
    localparam logic [AW-1:0] OFF_FDST_HI = 12'h01C;
    localparam logic [AW-1:0] OFF_PMIR0 = 12'h020;
    localparam logic [AW-1:0] OFF_PMIR1 = 12'h024;
    localparam logic [AW-1:0] OFF_TMEMB = 12'h040;
    localparam logic [AW-1:0] OFF_THASH = 12'h100;
    localparam logic [AW-1:0] TMEMB_MASK = 12'hFE0;
    localparam logic [AW-1:0] THASH_MASK = 12'hF00;

    localparam int CTRL_HSEL = 0;
    localparam int CTRL_RING = 2;
    localparam int CTRL_MDROP = 3;
    localparam int CTRL_FLOW = 4;
    localparam int CTRL_RFLOW = 5;
    localparam int CTRL_AMIR = 6;
    localparam int CTRL_MPORT = 8;
    localparam logic [31:0] CTRL_RST = 32'h0000_0008;

    localparam int PMIR_SRC = 0;
    localparam int PMIR_EGR = 4;
    localparam int PMIR_DST = 8;
    localparam int PMIR_EN = 12;

    localparam logic [1:0] HK_BOTH = 2'h0;
    localparam logic [1:0] HK_SRC = 2'h1;
    localparam logic [1:0] HK_DST = 2'h2;
    localparam logic [1:0] HK_PORT = 2'h3;

    typedef struct packed {
        logic          mirror;
        logic          match_src;
    } tafm_mir_t;

    typedef struct packed {
        logic          valid;
        logic          unicast;
        logic [PW-1:0] src_port;
        logic [47:0]   src_mac;
        logic [47:0]   dst_mac;
        logic [PW-1:0] dst_port;
        logic          dst_trunk;
        logic [2:0]    dst_group;
        tafm_mir_t     src_ent;
        tafm_mir_t     dst_ent;
        logic [NPORT-1:0] vlan_members;
    } tafm_req_t;

    typedef struct packed {
        logic             valid;
        logic             drop;
        logic [NPORT-1:0] fwd_ports;
        logic [NPORT-1:0] mir_ports;
    } tafm_dec_t;
endpackage

// ---- rtl/tafm_top.sv ----
// Forwarding decision with trunk resolution and mirroring, registers on APB
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
module tafm_top (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [tafm_pkg::AW-1:0]  paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire tafm_pkg::tafm_req_t      req,
    output tafm_pkg::tafm_dec_t           dec
);
    localparam int NP = tafm_pkg::NPORT;
    localparam int PW = tafm_pkg::PW;
    localparam int HW = 3;
    localparam int NSLICE = 48 / HW;

    // Fixed fold: same addresses always give the same index
    function automatic logic [2:0] fold48(input logic [47:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < NSLICE; i++) begin
            r = r ^ v[HW*i +: HW];
        end
        return r;
    endfunction

    function automatic logic [NP-1:0] onehot(input logic [PW-1:0] p);
        logic [NP-1:0] r;
        r = '0;
        if (int'(p) < NP) begin
            r[p] = 1'b1;
        end
        return r;
    endfunction

    // Register storage
    logic [31:0]      ctrl_reg;
    logic [47:0]      fsrc_reg;
    logic [47:0]      fdst_reg;
    logic [12:0]      pmir_reg [2];
    logic [NP-1:0]    tmemb_reg [tafm_pkg::NTRUNK];
    logic [PW-1:0]    thash_reg [tafm_pkg::NTRUNK*tafm_pkg::NHASH];
    logic [15:0]      frames_reg;
    logic [15:0]      drops_reg;
    logic [31:0]      prdata_reg;
    logic             pready_reg;
    logic             pslverr_reg;
    tafm_pkg::tafm_dec_t dec_reg;
    tafm_pkg::tafm_dec_t dec_next;

    // APB decode
    wire logic        setup_ph = psel & ~penable;
    wire logic        wr_acc   = psel & penable & pready_reg & pwrite;
    wire logic        hit_ctrl = paddr == tafm_pkg::OFF_CTRL;
    wire logic        hit_stat = paddr == tafm_pkg::OFF_STAT;
    wire logic        hit_fsl  = paddr == tafm_pkg::OFF_FSRC_LO;
    wire logic        hit_fsh  = paddr == tafm_pkg::OFF_FSRC_HI;
    wire logic        hit_fdl  = paddr == tafm_pkg::OFF_FDST_LO;
    wire logic        hit_fdh  = paddr == tafm_pkg::OFF_FDST_HI;
    wire logic        hit_pm0  = paddr == tafm_pkg::OFF_PMIR0;
    wire logic        hit_pm1  = paddr == tafm_pkg::OFF_PMIR1;
    wire logic        hit_tm   = (paddr & tafm_pkg::TMEMB_MASK) == tafm_pkg::OFF_TMEMB;
    wire logic        hit_th   = (paddr & tafm_pkg::THASH_MASK) == tafm_pkg::OFF_THASH;
    wire logic [2:0]  tm_idx   = paddr[4:2];
    wire logic [5:0]  th_idx   = paddr[7:2];
    wire logic        hit_any  = hit_ctrl | hit_stat | hit_fsl | hit_fsh | hit_fdl
                                 | hit_fdh | hit_pm0 | hit_pm1 | hit_tm | hit_th;

    // Write strobes, one per register group
    wire logic        we_ctrl  = wr_acc & hit_ctrl;
    wire logic        we_fsl   = wr_acc & hit_fsl;
    wire logic        we_fsh   = wr_acc & hit_fsh;
    wire logic        we_fdl   = wr_acc & hit_fdl;
    wire logic        we_fdh   = wr_acc & hit_fdh;
    wire logic        we_pm0   = wr_acc & hit_pm0;
    wire logic        we_pm1   = wr_acc & hit_pm1;
    wire logic        we_tm    = wr_acc & hit_tm;
    wire logic        we_th    = wr_acc & hit_th;

    // Control fields
    wire logic [1:0]    hsel     = ctrl_reg[tafm_pkg::CTRL_HSEL +: 2];
    wire logic          ring     = ctrl_reg[tafm_pkg::CTRL_RING];
    wire logic          mdrop_en = ctrl_reg[tafm_pkg::CTRL_MDROP];
    wire logic          flow_en  = ctrl_reg[tafm_pkg::CTRL_FLOW];
    wire logic          rflow_en = ctrl_reg[tafm_pkg::CTRL_RFLOW];
    wire logic          amir_en  = ctrl_reg[tafm_pkg::CTRL_AMIR];
    wire logic [PW-1:0] mport    = ctrl_reg[tafm_pkg::CTRL_MPORT +: PW];

    // Hash key choice; port key refused outside ring operation
    wire logic [2:0] key_both = fold48(req.src_mac ^ req.dst_mac);
    wire logic [2:0] key_src  = fold48(req.src_mac);
    wire logic [2:0] key_dst  = fold48(req.dst_mac);
    wire logic [2:0] key_port = req.src_port[2:0];
    wire logic [2:0] hkey     = (hsel == tafm_pkg::HK_SRC) ? key_src :
                                (hsel == tafm_pkg::HK_DST) ? key_dst :
                                (hsel == tafm_pkg::HK_PORT && ring) ? key_port :
                                key_both;

    wire logic [NP-1:0] src_bit = onehot(req.src_port);

    // Mirror destinations set up in port mode
    wire logic          pm_en0  = pmir_reg[0][tafm_pkg::PMIR_EN];
    wire logic          pm_en1  = pmir_reg[1][tafm_pkg::PMIR_EN];
    wire logic [NP-1:0] pm_dst0 = onehot(pmir_reg[0][tafm_pkg::PMIR_DST +: PW]);
    wire logic [NP-1:0] pm_dst1 = onehot(pmir_reg[1][tafm_pkg::PMIR_DST +: PW]);
    wire logic [NP-1:0] mir_dst_set = (pm_en0 ? pm_dst0 : '0) | (pm_en1 ? pm_dst1 : '0);

    // Unicast path
    wire logic [NP-1:0] dtrunk = tmemb_reg[req.dst_group];
    wire logic [PW-1:0] uc_mem = thash_reg[{req.dst_group, hkey}];
    wire logic [PW-1:0] uc_port = req.dst_trunk ? uc_mem : req.dst_port;
    wire logic          uc_same = req.dst_trunk & |(dtrunk & src_bit);

    // Address and flow mirror triggers
    wire logic a_mir = amir_en & ((req.src_ent.mirror & req.src_ent.match_src)
                                | (req.dst_ent.mirror & ~req.dst_ent.match_src));
    wire logic f_fwd = flow_en & (req.src_mac == fsrc_reg) & (req.dst_mac == fdst_reg);
    wire logic f_rev = rflow_en & (req.src_mac == fdst_reg) & (req.dst_mac == fsrc_reg);

    // Source trunk of the ingress port, for multicast pruning
    logic [NP-1:0] src_trunk;
    logic [NP-1:0] mc_set;
    logic [NP-1:0] fwd_set;
    logic [NP-1:0] mir_set;
    logic          drop_c;

    always_comb begin
        src_trunk = src_bit;
        for (int t = 0; t < tafm_pkg::NTRUNK; t++) begin
            if (|(tmemb_reg[t] & src_bit)) begin
                src_trunk = src_trunk | tmemb_reg[t];
            end
        end
    end

    always_comb begin
        logic [NP-1:0] keep;
        keep = '0;
        mc_set = req.vlan_members;
        mc_set = mc_set & ~src_trunk;
        for (int t = 0; t < tafm_pkg::NTRUNK; t++) begin
            if (|(mc_set & tmemb_reg[t])) begin
                keep = onehot(thash_reg[t*tafm_pkg::NHASH + int'(hkey)]);
                mc_set = (mc_set & ~tmemb_reg[t]) | (mc_set & keep);
            end
        end
    end

    always_comb begin
        logic [NP-1:0] raw;
        raw = req.unicast ? onehot(uc_port) : mc_set;
        drop_c = req.unicast & uc_same;
        // Enabled port-mirror destinations never carry normal traffic; the mport output can
        fwd_set = drop_c ? '0 : (raw & ~mir_dst_set);
        mir_set = '0;
        if (a_mir || f_fwd || f_rev) begin
            mir_set = mir_set | onehot(mport);
        end
        for (int k = 0; k < 2; k++) begin
            if (pmir_reg[k][tafm_pkg::PMIR_EN]) begin
                // Egress match looks at the pruned set so trunk choice is honoured
                if (pmir_reg[k][tafm_pkg::PMIR_EGR]) begin
                    if (|(fwd_set & onehot(pmir_reg[k][tafm_pkg::PMIR_SRC +: PW]))) begin
                        mir_set = mir_set | onehot(pmir_reg[k][tafm_pkg::PMIR_DST +: PW]);
                    end
                end else if (req.src_port == pmir_reg[k][tafm_pkg::PMIR_SRC +: PW]) begin
                    mir_set = mir_set | onehot(pmir_reg[k][tafm_pkg::PMIR_DST +: PW]);
                end
            end
        end
        if (drop_c && !mdrop_en) begin
            mir_set = '0;
        end
        dec_next.valid     = req.valid;
        dec_next.drop      = req.valid & drop_c;
        dec_next.fwd_ports = req.valid ? fwd_set : '0;
        dec_next.mir_ports = req.valid ? mir_set : '0;
    end

    // Decision register: one cycle from request to answer, same for every flow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dec_reg <= '0;
        end else begin
            dec_reg <= dec_next;
        end
    end

    // Status counters show the block's own activity
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frames_reg <= 16'h0000;
            drops_reg  <= 16'h0000;
        end else if (req.valid) begin
            frames_reg <= frames_reg + 16'h0001;
            if (drop_c) begin
                drops_reg <= drops_reg + 16'h0001;
            end
        end
    end

    // Register writes land at the access edge only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= tafm_pkg::CTRL_RST;
        end else if (we_ctrl) begin
            ctrl_reg <= pwdata;
        end
    end

    // Low and high words are independent, so software may write them in any order
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fsrc_reg <= '0;
        end else begin
            if (we_fsl) begin
                fsrc_reg[31:0] <= pwdata;
            end
            if (we_fsh) begin
                fsrc_reg[47:32] <= pwdata[15:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fdst_reg <= '0;
        end else begin
            if (we_fdl) begin
                fdst_reg[31:0] <= pwdata;
            end
            if (we_fdh) begin
                fdst_reg[47:32] <= pwdata[15:0];
            end
        end
    end

    // A new mirror destination applies from the next decision on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pmir_reg <= '{default: '0};
        end else begin
            if (we_pm0) begin
                pmir_reg[0] <= pwdata[12:0];
            end
            if (we_pm1) begin
                pmir_reg[1] <= pwdata[12:0];
            end
        end
    end

    // Trunk tables: member masks and hash entries
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmemb_reg <= '{default: '0};
            thash_reg <= '{default: '0};
        end else begin
            if (we_tm) begin
                tmemb_reg[tm_idx] <= pwdata[NP-1:0];
            end
            if (we_th) begin
                thash_reg[th_idx] <= pwdata[PW-1:0];
            end
        end
    end

    // Read mux
    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h0000_0000;
        // Address decodes are disjoint, so the order of the tests does not matter
        if (hit_ctrl) begin
            rd_val = ctrl_reg;
        end
        if (hit_stat) begin
            rd_val = {drops_reg, frames_reg};
        end
        if (hit_fsl) begin
            rd_val = fsrc_reg[31:0];
        end
        if (hit_fsh) begin
            rd_val = {16'h0000, fsrc_reg[47:32]};
        end
        if (hit_fdl) begin
            rd_val = fdst_reg[31:0];
        end
        if (hit_fdh) begin
            rd_val = {16'h0000, fdst_reg[47:32]};
        end
        if (hit_pm0) begin
            rd_val = {19'h0_0000, pmir_reg[0]};
        end
        if (hit_pm1) begin
            rd_val = {19'h0_0000, pmir_reg[1]};
        end
        if (hit_tm) begin
            rd_val = {{(32-NP){1'b0}}, tmemb_reg[tm_idx]};
        end
        if (hit_th) begin
            rd_val = {{(32-PW){1'b0}}, thash_reg[th_idx]};
        end
    end

    // Answer in the access cycle; unmapped addresses error and read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg  <= setup_ph;
            pslverr_reg <= setup_ph & ~hit_any;
            prdata_reg  <= (setup_ph & ~pwrite) ? rd_val : 32'h0000_0000;
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign dec     = dec_reg;
endmodule

// ---- sim/tafm_assertions.sv ----
// Port-level assertions for the trunk-aware forwarder
`timescale 1ns/10ps
module tafm_assertions (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [11:0]          paddr,
    input wire logic [31:0]          pwdata,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire tafm_pkg::tafm_req_t  req,
    input wire tafm_pkg::tafm_dec_t  dec
);
    logic [9:0] src_bit;
    logic [9:0] dst_bit;
    logic       wr_acc;
    // Port numbers of 10 and up shift out and give no bit
    assign src_bit = 10'h001 << req.src_port;
    assign dst_bit = 10'h001 << req.dst_port;
    assign wr_acc = psel && penable && pwrite;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_mcast;
        req.valid && !req.unicast;
    endsequence
    property p_lat;
        req.valid |=> dec.valid;
    endproperty
    a_lat: assert property (p_lat) else $error("decision pulse missing");
    property p_drop;
        dec.valid && dec.drop |-> dec.fwd_ports == '0;
    endproperty
    a_drop: assert property (p_drop) else $error("dropped frame forwarded");
    property p_direct;
        req.valid && req.unicast && !req.dst_trunk
            |=> !dec.drop && (dec.fwd_ports & ~$past(dst_bit)) == '0;
    endproperty
    a_direct: assert property (p_direct) else $error("plain unicast misrouted");
    property p_uni_one;
        req.valid && req.unicast |=> $countones(dec.fwd_ports) <= 1;
    endproperty
    a_uni_one: assert property (p_uni_one) else $error("unicast to several ports");
    property p_vlan;
        s_mcast |=> (dec.fwd_ports & ~$past(req.vlan_members)) == '0;
    endproperty
    a_vlan: assert property (p_vlan) else $error("multicast outside vlan");
    property p_srcx;
        s_mcast |=> (dec.fwd_ports & $past(src_bit)) == '0;
    endproperty
    a_srcx: assert property (p_srcx) else $error("multicast back to source");
    // Same flow with no register write between must take the same member
    property p_det;
        req.valid && $past(req.valid) && req == $past(req) && !$past(wr_acc)
            |=> dec == $past(dec);
    endproperty
    a_det: assert property (p_det) else $error("decision not repeatable");
    property p_rdy;
        s_setup |=> pready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("no access answer");
    property p_err;
        pslverr |-> pready && prdata == '0;
    endproperty
    a_err: assert property (p_err) else $error("error without ready");
endmodule
bind tafm_top tafm_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .req, .dec);

// ---- sim/tafm_se_model.sv ----
// Search engine side model: one lookup result per cycle of fire
`timescale 1ns/10ps
module tafm_se_model (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 fire,
    input  wire tafm_pkg::tafm_req_t  next_req,
    output tafm_pkg::tafm_req_t       req
);
    // Idle fields are inverted so the block cannot lean on stale values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req <= '0;
        end else if (fire) begin
            req       <= next_req;
            req.valid <= 1'b1;
        end else begin
            req       <= ~req;
            req.valid <= 1'b0;
        end
    end
endmodule

// ---- sim/test_trunk_aware_forward_mirror.sv ----
// Self-checking bench for the trunk-aware forwarder with mirroring
`timescale 1ns/10ps
module test_trunk_aware_forward_mirror;
    typedef struct packed {
        logic       uni;
        logic [3:0] src;
        logic [7:0] dmac;
        logic [3:0] dport;
        logic       trk;
        logic [9:0] vlan;
        logic       drop;
        logic [9:0] fwd;
    } tafm_row_t;
    logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, fire;
    logic [11:0]         paddr;
    logic [31:0]         pwdata, prdata;
    tafm_pkg::tafm_req_t req, next_req;
    tafm_pkg::tafm_dec_t dec;
    int                  mismatches = 0;
    int                  check_count = 0;
    // Trunk 0 = ports 0..2, trunk 1 = ports 3..4, source MAC zero
    tafm_row_t rows [7] = '{
        '{1'b1, 4'h5, 8'h05, 4'h7, 1'b0, 10'h000, 1'b0, 10'h080},
        '{1'b1, 4'h5, 8'h05, 4'h0, 1'b1, 10'h000, 1'b0, 10'h004},
        '{1'b1, 4'h1, 8'h05, 4'h0, 1'b1, 10'h000, 1'b1, 10'h000},
        '{1'b1, 4'h9, 8'h03, 4'h0, 1'b1, 10'h000, 1'b0, 10'h001},
        '{1'b0, 4'h3, 8'h05, 4'h0, 1'b0, 10'h07F, 1'b0, 10'h064},
        '{1'b0, 4'h6, 8'h03, 4'h0, 1'b0, 10'h07F, 1'b0, 10'h031},
        '{1'b0, 4'h0, 8'h00, 4'h0, 1'b0, 10'h07F, 1'b0, 10'h068}};
    logic [3:0] hsel [5] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'hF};
    logic [9:0] hexp [5] = '{10'h002, 10'h001, 10'h004, 10'h002, 10'h004};

    tafm_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .req, .dec);
    tafm_se_model u_se (.pclk, .presetn, .fire, .next_req, .req);

    always #25 pclk = ~pclk;

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] exp);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, pready, 1'b1);
        end
        if (!w) chk({pslverr, prdata}, exp);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic tafm_pkg::tafm_req_t mk(input logic u, input logic [3:0] s,
        input logic [47:0] sm, input logic [47:0] dm, input logic [3:0] dp, input logic t,
        input logic [9:0] v, input logic [1:0] se, input logic [1:0] de);
        return '{1'b1, u, s, sm, dm, dp, t, 3'h0, se, de, v};
    endfunction

    // Each lookup goes twice back to back; both answers must agree
    task automatic send(input tafm_pkg::tafm_req_t r, input logic [20:0] exp);
        int n;
        fire <= 1'b1;
        next_req <= r;
        repeat (2) @(posedge pclk);
        fire <= 1'b0;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (dec.valid !== 1'b1 && n < 8);
        repeat (2) begin
            chk({11'h000, dec.valid, dec.drop, dec.fwd_ports, dec.mir_ports},
                {11'h000, 1'b1, exp});
            @(negedge pclk);
        end
        chk({32'h0000_0000, dec.valid}, 33'h0_0000_0000);
        @(posedge pclk);
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, fire, paddr, pwdata, next_req} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, tafm_pkg::OFF_CTRL, '0, {1'b0, tafm_pkg::CTRL_RST});
        apb(1'b0, 12'h030, '0, 33'h1_0000_0000);
        $display("reset test done");
        apb(1'b1, tafm_pkg::OFF_TMEMB, 32'h0000_0007, '0);
        apb(1'b1, tafm_pkg::OFF_TMEMB + 12'h004, 32'h0000_0018, '0);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, tafm_pkg::OFF_THASH + 12'(4 * i), 32'(i % 3), '0);
            apb(1'b1, tafm_pkg::OFF_THASH + 12'(32 + 4 * i), 32'(3 + i % 2), '0);
        end
        apb(1'b0, tafm_pkg::OFF_THASH + 12'h01C, '0, 33'h0_0000_0001);
        $display("trunk setup test done");
        foreach (rows[k]) begin
            send(mk(rows[k].uni, rows[k].src, 48'h0, {40'h0, rows[k].dmac}, rows[k].dport,
                rows[k].trk, rows[k].vlan, 2'h0, 2'h0), {rows[k].drop, rows[k].fwd, 10'h000});
        end
        $display("forwarding table test done");
        // Key source 3 without ring mode falls back to both addresses
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, tafm_pkg::OFF_CTRL, {28'h000_0000, hsel[i]}, '0);
            send(mk(1'b1, 4'h5, 48'h6, 48'h2, 4'h0, 1'b1, 10'h000, 2'h0, 2'h0),
                {1'b0, hexp[i], 10'h000});
        end
        $display("hash key select test done");
        apb(1'b1, tafm_pkg::OFF_FSRC_LO, 32'h0000_0006, '0);
        apb(1'b1, tafm_pkg::OFF_FDST_LO, 32'h0000_0002, '0);
        apb(1'b1, tafm_pkg::OFF_CTRL, 32'h0000_0918, '0);
        send(mk(1'b1, 4'h5, 48'h6, 48'h2, 4'h7, 1'b0, '0, 2'h0, 2'h0), 21'h02_0200);
        send(mk(1'b1, 4'h5, 48'h2, 48'h6, 4'h7, 1'b0, '0, 2'h0, 2'h0), 21'h02_0000);
        apb(1'b1, tafm_pkg::OFF_CTRL, 32'h0000_0938, '0);
        send(mk(1'b1, 4'h5, 48'h2, 48'h6, 4'h7, 1'b0, '0, 2'h0, 2'h0), 21'h02_0200);
        apb(1'b1, tafm_pkg::OFF_CTRL, 32'h0000_0948, '0);
        send(mk(1'b1, 4'h5, 48'h6, 48'h2, 4'h7, 1'b0, '0, 2'h3, 2'h0), 21'h02_0200);
        send(mk(1'b1, 4'h5, 48'h6, 48'h2, 4'h7, 1'b0, '0, 2'h2, 2'h0), 21'h02_0000);
        send(mk(1'b1, 4'h5, 48'h6, 48'h2, 4'h7, 1'b0, '0, 2'h0, 2'h2), 21'h02_0200);
        send(mk(1'b1, 4'h1, 48'h6, 48'h2, 4'h0, 1'b1, '0, 2'h3, 2'h0), 21'h10_0200);
        apb(1'b1, tafm_pkg::OFF_CTRL, 32'h0000_0940, '0);
        send(mk(1'b1, 4'h1, 48'h6, 48'h2, 4'h0, 1'b1, '0, 2'h3, 2'h0), 21'h10_0000);
        apb(1'b1, tafm_pkg::OFF_CTRL, 32'h0000_0008, '0);
        apb(1'b1, tafm_pkg::OFF_PMIR0, 32'h0000_1807, '0);
        apb(1'b1, tafm_pkg::OFF_PMIR1, 32'h0000_1917, '0);
        send(mk(1'b1, 4'h7, 48'h6, 48'h2, 4'h5, 1'b0, '0, 2'h0, 2'h0), 21'h00_8100);
        send(mk(1'b1, 4'h5, 48'h6, 48'h2, 4'h7, 1'b0, '0, 2'h0, 2'h0), 21'h02_0200);
        send(mk(1'b1, 4'h5, 48'h6, 48'h2, 4'h8, 1'b0, '0, 2'h0, 2'h0), 21'h00_0000);
        // Loopback set-up as a remote manager would do it: port 5 ingress back to port 5
        apb(1'b1, tafm_pkg::OFF_PMIR0, 32'h0000_1505, '0);
        apb(1'b1, tafm_pkg::OFF_PMIR1, 32'h0000_0000, '0);
        send(mk(1'b1, 4'h5, 48'h6, 48'h2, 4'h7, 1'b0, '0, 2'h0, 2'h0), 21'h02_0020);
        $display("mirroring test done");
        // 24 lookups sent twice each, three of them dropped
        apb(1'b0, tafm_pkg::OFF_STAT, '0, 33'h0_0006_0030);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({11'h000, dec.valid, dec.drop, dec.fwd_ports, dec.mir_ports},
            33'h0_0000_0000);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, tafm_pkg::OFF_CTRL, '0, {1'b0, tafm_pkg::CTRL_RST});
        apb(1'b0, tafm_pkg::OFF_STAT, '0, 33'h0_0000_0000);
        $display("mid-run reset test done");
        give_verdict();
    end

    // The whole sequence needs well under 2000 cycles; allow about ten times that
    initial begin
        #1_000_000;
        mismatches++;
        $display("watchdog expired");
        give_verdict();
    end
endmodule
